/* common/kpst_pkg.sv */
// Constants of the keypad key status register bank: offsets, widths, reset values.
// Assumes a single 25 MHz clock and a plain register port with one-cycle strobes.
// Operation
// - Release flags: bit 7 key I, bit 0 P.
// - Release flags clear when their register is read.
// - Flag reads 1 only after recorded release event.
// - Live low: key A bit 7, H bit 0.
// - Live high: key I bit 7, P bit 0.
// - Live bit is 1 pressed, 0 released.
package kpst_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int KPST_AW    = 8;
    localparam int KPST_DW    = 8;
    localparam int KPST_NKEYS = 16;
    localparam int KPST_HALF  = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [KPST_AW-1:0] KPST_OFS_RELEASE_HIGH = 8'h23;
    localparam logic [KPST_AW-1:0] KPST_OFS_LIVE_LOW     = 8'h24;
    localparam logic [KPST_AW-1:0] KPST_OFS_LIVE_HIGH    = 8'h25;
    localparam logic [KPST_AW-1:0] KPST_OFS_INT_STATUS   = 8'h26;
    localparam logic [KPST_AW-1:0] KPST_OFS_INT_MASK     = 8'h27;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [KPST_DW-1:0] KPST_RST_FLAGS  = 8'h00;
    localparam logic [KPST_DW-1:0] KPST_RST_MASK   = 8'h00;
    localparam logic [KPST_DW-1:0] KPST_RST_RDATA  = 8'h00;
    localparam logic [KPST_DW-1:0] KPST_UNMAPPED   = 8'h00;

endpackage

/* common/kpst_flag_if.sv */
// Carrier between the register bank and its release flag bank.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface kpst_flag_if;
    logic [kpst_pkg::KPST_HALF-1:0] key_now;
    logic [kpst_pkg::KPST_HALF-1:0] clr;
    logic [kpst_pkg::KPST_HALF-1:0] evt;
    logic [kpst_pkg::KPST_HALF-1:0] flags;

    modport owner (input key_now, input clr, output evt, output flags);
    modport user  (output key_now, output clr, input evt, input flags);
endinterface

/* rtl/kpst_flag_bank.sv */
// Release flag bank for keys I to P: edge detection and clear-on-read flags.
// Assumes key_now is live key state on the same clock, bit 7 key I to bit 0 key P.
`timescale 1ns/10ps
module kpst_flag_bank (
    input  wire logic   mclk,
    input  wire logic   sys_rst,
    kpst_flag_if.owner  fb
);

    logic [kpst_pkg::KPST_HALF-1:0] prev_q;
    logic [kpst_pkg::KPST_HALF-1:0] flags_q;
    logic [kpst_pkg::KPST_HALF-1:0] flags_d;

    // ------------------------------------------------------------------
    // Release detection
    // ------------------------------------------------------------------
    // Previous state resets to released so no release is seen out of reset.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= fb.key_now;
        end
    end

    assign fb.evt = prev_q & ~fb.key_now;

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------
    // A release in the same cycle as the clearing read survives the clear.
    always_comb begin
        flags_d = (flags_q & ~fb.clr) | fb.evt;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_q <= kpst_pkg::KPST_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign fb.flags = flags_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_release_sets_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        (|fb.evt) |=> ((flags_q & $past(fb.evt)) == $past(fb.evt)))
        else $error("release event did not set its flag");

    a_read_clears_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        ((&fb.clr) && (fb.evt == '0)) |=> (flags_q == '0))
        else $error("flags not cleared by read");

    a_flag_needs_event: assert property (@(posedge mclk) disable iff (sys_rst)
        ((flags_q & ~$past(flags_q) & ~$past(fb.evt)) == '0))
        else $error("flag set without a release event");

endmodule

/* rtl/kpst_regs.sv */
// Keypad key status register bank: release flags of keys I to P, live state of
// keys A to P, and an interrupt status and mask pair for the release events.
// Assumes key_down comes from the keypad scanner on mclk, bit 15 key A to bit 0
// key P, 1 while pressed; the register port is driven on the same clock.
`timescale 1ns/10ps
module kpst_regs (
    input  wire logic                            mclk,
    input  wire logic                            sys_rst,
    input  wire logic [kpst_pkg::KPST_NKEYS-1:0] key_down,
    input  wire logic [kpst_pkg::KPST_AW-1:0]    reg_addr,
    input  wire logic [kpst_pkg::KPST_DW-1:0]    reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [kpst_pkg::KPST_DW-1:0]    reg_rdata,
    output logic                                 irq
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [kpst_pkg::KPST_AW-1:0] a,
                                 input logic [kpst_pkg::KPST_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Readable offsets; any other address reads as the unmapped value and
    // ignores writes.
    function automatic logic mapped(input logic [kpst_pkg::KPST_AW-1:0] a);
        mapped = hit(a, kpst_pkg::KPST_OFS_RELEASE_HIGH)
              || hit(a, kpst_pkg::KPST_OFS_LIVE_LOW)
              || hit(a, kpst_pkg::KPST_OFS_LIVE_HIGH)
              || hit(a, kpst_pkg::KPST_OFS_INT_STATUS)
              || hit(a, kpst_pkg::KPST_OFS_INT_MASK);
    endfunction

    logic rd_release;
    logic rd_live_low;
    logic rd_live_high;
    logic rd_int_status;
    logic rd_int_mask;
    logic wr_int_status;
    logic wr_int_mask;

    assign rd_release    = reg_rd && hit(reg_addr, kpst_pkg::KPST_OFS_RELEASE_HIGH);
    assign rd_live_low   = reg_rd && hit(reg_addr, kpst_pkg::KPST_OFS_LIVE_LOW);
    assign rd_live_high  = reg_rd && hit(reg_addr, kpst_pkg::KPST_OFS_LIVE_HIGH);
    assign rd_int_status = reg_rd && hit(reg_addr, kpst_pkg::KPST_OFS_INT_STATUS);
    assign rd_int_mask   = reg_rd && hit(reg_addr, kpst_pkg::KPST_OFS_INT_MASK);
    assign wr_int_status = reg_wr && hit(reg_addr, kpst_pkg::KPST_OFS_INT_STATUS);
    assign wr_int_mask   = reg_wr && hit(reg_addr, kpst_pkg::KPST_OFS_INT_MASK);

    // ------------------------------------------------------------------
    // Live key state split
    // ------------------------------------------------------------------
    logic [kpst_pkg::KPST_HALF-1:0] live_low;
    logic [kpst_pkg::KPST_HALF-1:0] live_high;

    assign live_low  = key_down[kpst_pkg::KPST_NKEYS-1:kpst_pkg::KPST_HALF];
    assign live_high = key_down[kpst_pkg::KPST_HALF-1:0];

    // ------------------------------------------------------------------
    // Release flag bank
    // ------------------------------------------------------------------
    kpst_flag_if flag_bus ();

    assign flag_bus.key_now = live_high;
    // Only a read of the release register clears; reads of the live registers
    // and every write leave the flags alone.
    assign flag_bus.clr = rd_release ? '1 : '0;

    kpst_flag_bank u_flags (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .fb      (flag_bus.owner)
    );

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    // This pair mirrors the release events for software that prefers a
    // write-one-to-clear flow; it does not disturb the clear-on-read flags.
    logic [kpst_pkg::KPST_DW-1:0] int_status_q;
    logic [kpst_pkg::KPST_DW-1:0] int_status_d;
    logic [kpst_pkg::KPST_DW-1:0] int_mask_q;

    always_comb begin
        int_status_d = int_status_q;
        if (wr_int_status) begin
            int_status_d = int_status_d & ~reg_wdata;
        end
        int_status_d = int_status_d | flag_bus.evt;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            int_status_q <= kpst_pkg::KPST_RST_FLAGS;
        end else begin
            int_status_q <= int_status_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            int_mask_q <= kpst_pkg::KPST_RST_MASK;
        end else if (wr_int_mask) begin
            int_mask_q <= reg_wdata;
        end
    end

    // The output is registered from the next status, so it changes in step with the
    // status register; a new mask takes effect one cycle after the mask register.
    // Software that masks and then reads may see one last high cycle.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status_d & int_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Writes to the three status registers fall through here unused.
    logic [kpst_pkg::KPST_DW-1:0] rdata_d;

    always_comb begin
        rdata_d = kpst_pkg::KPST_UNMAPPED;
        if (rd_release) begin
            rdata_d = flag_bus.flags;
        end else if (rd_live_low) begin
            rdata_d = live_low;
        end else if (rd_live_high) begin
            rdata_d = live_high;
        end else if (rd_int_status) begin
            rdata_d = int_status_q;
        end else if (rd_int_mask) begin
            rdata_d = int_mask_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= kpst_pkg::KPST_RST_RDATA;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_release_read_value: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == kpst_pkg::KPST_OFS_RELEASE_HIGH)
        |=> (reg_rdata == $past(flag_bus.flags)))
        else $error("release register read returned wrong value");

    a_live_low_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == kpst_pkg::KPST_OFS_LIVE_LOW)
        |=> (reg_rdata == $past(key_down[15:8])))
        else $error("live low register does not show keys A to H");

    a_live_high_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == kpst_pkg::KPST_OFS_LIVE_HIGH)
        |=> (reg_rdata == $past(key_down[7:0])))
        else $error("live high register does not show keys I to P");

    a_live_tracks_key: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && reg_addr == kpst_pkg::KPST_OFS_LIVE_HIGH && key_down[7])
        |=> reg_rdata[7])
        else $error("pressed key I does not read as 1");

    a_live_no_side: assert property (@(posedge mclk) disable iff (sys_rst)
        ((reg_rd || reg_wr) && reg_addr != kpst_pkg::KPST_OFS_RELEASE_HIGH
         && flag_bus.evt == '0)
        |=> (flag_bus.flags == $past(flag_bus.flags)))
        else $error("flags changed by a non-clearing access");

    a_write_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && reg_addr == kpst_pkg::KPST_OFS_RELEASE_HIGH && flag_bus.evt == '0)
        |=> (flag_bus.flags == $past(flag_bus.flags)))
        else $error("write to release register changed flags");

    a_irq_follows_mask: assert property (@(posedge mclk) disable iff (sys_rst)
        ##1 (irq == |($past(int_status_d) & $past(int_mask_q))))
        else $error("interrupt output does not follow masked status");

    // ------------------------------------------------------------------
    // Checks: live state
    // ------------------------------------------------------------------
    a_key_a_pressed: assert property (@(posedge mclk) disable iff (sys_rst)
        (rd_live_low && key_down[kpst_pkg::KPST_NKEYS-1])
        |=> reg_rdata[kpst_pkg::KPST_DW-1])
        else $error("pressed key A does not read as 1");

    a_key_i_released: assert property (@(posedge mclk) disable iff (sys_rst)
        (rd_live_high && !key_down[kpst_pkg::KPST_HALF-1])
        |=> !reg_rdata[kpst_pkg::KPST_DW-1])
        else $error("released key I does not read as 0");

    a_key_p_released: assert property (@(posedge mclk) disable iff (sys_rst)
        (rd_live_high && !key_down[0])
        |=> !reg_rdata[0])
        else $error("released key P does not read as 0");

    // ------------------------------------------------------------------
    // Checks: release flags
    // ------------------------------------------------------------------
    a_key_i_release: assert property (@(posedge mclk) disable iff (sys_rst)
        (key_down[kpst_pkg::KPST_HALF-1] ##1 !key_down[kpst_pkg::KPST_HALF-1])
        |=> flag_bus.flags[kpst_pkg::KPST_HALF-1])
        else $error("release of key I did not set bit 7");

    a_key_p_release: assert property (@(posedge mclk) disable iff (sys_rst)
        (key_down[0] ##1 !key_down[0]) |=> flag_bus.flags[0])
        else $error("release of key P did not set bit 0");

    // Set wins: a release that lands on the clearing read survives it.
    a_clear_keeps_event: assert property (@(posedge mclk) disable iff (sys_rst)
        ((&flag_bus.clr) && (flag_bus.evt != '0))
        |=> (flag_bus.flags == $past(flag_bus.evt)))
        else $error("release lost in the clearing read");

    a_read_keeps_status: assert property (@(posedge mclk) disable iff (sys_rst)
        (rd_release && flag_bus.evt == '0) |=> $stable(int_status_q))
        else $error("release register read disturbed the status register");

    // ------------------------------------------------------------------
    // Checks: read port
    // ------------------------------------------------------------------
    // Read data falls back to zero between reads, so a host that samples a
    // cycle late sees an idle port rather than stale register contents.
    a_rdata_idle_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        !reg_rd |=> (reg_rdata == kpst_pkg::KPST_RST_RDATA))
        else $error("read data not idle after a cycle without read");

    a_unmapped_read_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_rd && !mapped(reg_addr)) |=> (reg_rdata == kpst_pkg::KPST_UNMAPPED))
        else $error("unmapped read returned nonzero data");

    a_status_read_value: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_int_status |=> (reg_rdata == $past(int_status_q)))
        else $error("status register read returned wrong value");

    a_mask_read_value: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_int_mask |=> (reg_rdata == $past(int_mask_q)))
        else $error("mask register read returned wrong value");

    a_reset_outputs_low: assert property (@(posedge mclk)
        sys_rst |=> (reg_rdata == kpst_pkg::KPST_RST_RDATA && !irq
                     && flag_bus.flags == kpst_pkg::KPST_RST_FLAGS
                     && int_mask_q == kpst_pkg::KPST_RST_MASK))
        else $error("state not cleared by reset");

    // ------------------------------------------------------------------
    // Checks: writes
    // ------------------------------------------------------------------
    a_live_write_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && flag_bus.evt == '0
         && (hit(reg_addr, kpst_pkg::KPST_OFS_LIVE_LOW)
             || hit(reg_addr, kpst_pkg::KPST_OFS_LIVE_HIGH)))
        |=> ($stable(flag_bus.flags) && $stable(int_status_q) && $stable(int_mask_q)))
        else $error("write to a live state register changed state");

    a_stray_write_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
        (reg_wr && !mapped(reg_addr)) |=> $stable(int_mask_q))
        else $error("write to an unmapped address changed the mask");

    // ------------------------------------------------------------------
    // Checks: interrupt status and mask
    // ------------------------------------------------------------------
    a_event_sets_status: assert property (@(posedge mclk) disable iff (sys_rst)
        (flag_bus.evt != '0)
        |=> ((int_status_q & $past(flag_bus.evt)) == $past(flag_bus.evt)))
        else $error("release event did not set its status bit");

    a_status_write_clears: assert property (@(posedge mclk) disable iff (sys_rst)
        (wr_int_status && flag_bus.evt == '0)
        |=> (int_status_q == ($past(int_status_q) & ~$past(reg_wdata))))
        else $error("write of ones did not clear status bits");

    a_status_holds: assert property (@(posedge mclk) disable iff (sys_rst)
        (!wr_int_status && flag_bus.evt == '0) |=> $stable(int_status_q))
        else $error("status register changed without event or write");

    a_mask_takes_write: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_int_mask |=> (int_mask_q == $past(reg_wdata)))
        else $error("mask register did not take the written value");

    a_mask_holds: assert property (@(posedge mclk) disable iff (sys_rst)
        !wr_int_mask |=> $stable(int_mask_q))
        else $error("mask register changed without a write");

    a_irq_needs_status: assert property (@(posedge mclk) disable iff (sys_rst)
        irq |-> (int_status_q != '0))
        else $error("interrupt high with no status bit set");

    a_irq_masked_off: assert property (@(posedge mclk) disable iff (sys_rst)
        (int_mask_q == '0) |=> !irq)
        else $error("interrupt high while every bit is masked");

    a_irq_rises: assert property (@(posedge mclk) disable iff (sys_rst)
        (|(int_status_d & int_mask_q)) |=> irq)
        else $error("interrupt did not rise for an unmasked status bit");

    a_irq_drops: assert property (@(posedge mclk) disable iff (sys_rst)
        ((int_status_d & int_mask_q) == '0) |=> !irq)
        else $error("interrupt stayed high with no unmasked status bit");

endmodule

/* bench/kpst_host.sv */
// Host model: the processor side of the key status register port.
// Assumes one clock; strobes last one cycle, read data is taken the cycle after.
`timescale 1ns/10ps
module kpst_host (
    input  wire logic                         mclk,
    input  wire logic [kpst_pkg::KPST_DW-1:0] reg_rdata,
    output logic      [kpst_pkg::KPST_AW-1:0] reg_addr,
    output logic      [kpst_pkg::KPST_DW-1:0] reg_wdata,
    output logic                              reg_wr,
    output logic                              reg_rd
);
    // After an access the address shows the inverse of the last one, so a stale address never passes.
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

/* bench/kpst_regs_tb.sv */
// Self-checking bench of the key status register bank.
// Assumes the host model drives the register port; keys are driven here.
`timescale 1ns/10ps
module kpst_regs_tb;
    logic [kpst_pkg::KPST_NKEYS-1:0] key_down;
    logic [kpst_pkg::KPST_AW-1:0]    reg_addr;
    logic [kpst_pkg::KPST_DW-1:0]    reg_wdata;
    logic [kpst_pkg::KPST_DW-1:0]    reg_rdata;
    logic [kpst_pkg::KPST_DW-1:0]    rv;
    logic [kpst_pkg::KPST_DW-1:0]    r;
    logic [31:0]                     seed;
    logic                            mclk;
    logic                            sys_rst;
    logic                            reg_wr;
    logic                            reg_rd;
    logic                            irq;
    int                              err_count;
    int                              n_tests;

    kpst_regs uut (.mclk(mclk), .sys_rst(sys_rst), .key_down(key_down),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    kpst_host host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] live_exp(input logic [15:0] k, input logic hi);
        return hi ? k[7:0] : k[15:8];
    endfunction

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t irq %b expected %b", $time, got, exp);
        end
    endtask

    task automatic set_keys(input logic [15:0] k);
        @(posedge mclk);
        key_down <= k;
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        close_out;
    end

    initial begin
        sys_rst   = 1'b1;
        key_down  = 16'h0000;
        err_count = 0;
        n_tests   = 0;
        seed      = 32'h77468515;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 8'h23; a <= 8'h28; a++) begin
            host.rd(a[7:0], rv);
            chk8(rv, 8'h00);
        end
        chk1(irq, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            set_keys(seed[15:0]);
            host.rd(8'h24, rv);
            chk8(rv, live_exp(key_down, 1'b0));
            host.rd(8'h25, rv);
            chk8(rv, live_exp(key_down, 1'b1));
            host.rd(8'h25, rv);
            chk8(rv, live_exp(key_down, 1'b1));
        end
        set_keys(16'h0000);
        $display("test live done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            r = (i == 0) ? 8'h80 : (i == 1) ? 8'hff : seed[7:0];
            host.rd(8'h23, rv);
            set_keys({seed[15:8], r});
            set_keys({seed[15:8], 8'h00});
            host.wr(8'h23, 8'h00);
            host.wr(8'h25, 8'hff);
            host.rd(8'h25, rv);
            chk8(rv, 8'h00);
            host.rd(8'h23, rv);
            chk8(rv, r);
            host.rd(8'h23, rv);
            chk8(rv, 8'h00);
            host.rd(8'h24, rv);
            chk8(rv, live_exp(key_down, 1'b0));
        end
        $display("test flags done");
        host.wr(8'h26, 8'hff);
        host.wr(8'h27, 8'h80);
        host.rd(8'h27, rv);
        chk8(rv, 8'h80);
        set_keys(16'h0001);
        set_keys(16'h0000);
        repeat (3) @(posedge mclk);
        chk1(irq, 1'b0);
        set_keys(16'h0080);
        set_keys(16'h0000);
        repeat (3) @(posedge mclk);
        chk1(irq, 1'b1);
        host.rd(8'h23, rv);
        chk8(rv, 8'h81);
        host.rd(8'h26, rv);
        chk8(rv, 8'h81);
        host.wr(8'h26, 8'h80);
        repeat (3) @(posedge mclk);
        chk1(irq, 1'b0);
        host.rd(8'h26, rv);
        chk8(rv, 8'h01);
        $display("test irq done");
        close_out;
    end
endmodule
